/* File: logic/ehpc_pkg.sv */
// Constants, register map and mode codes of the position counter.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word each.
// Notes on behaviour
// RULE1: Encoder mode makes one edge pulse per A/B change, four per cycle.
// RULE2: Clockwise encoder count rises; after reaching reload it wraps to zero.
// RULE3: Counter-clockwise encoder count falls; after zero it loads reload.
// RULE4: With Z clear on, Z rise (cw) or fall (ccw) clears count.
// RULE5: Edge pulse together with Z clear gives zero, not a step.
// RULE6: Writing the clear bit forces the counter to zero in any mode.
// RULE7: Direction flag is one for clockwise, zero for counter-clockwise.
// RULE8: Edge pulses divided by a programmed factor drive an output pin.
// RULE9: Encoder compare match interrupts, muted while Z clear on and no Z.
// RULE10: Encoder mode drops run enable when Z-seen and direction are zero.
// RULE11: Sensor modes pulse four per cycle from U,V or six from U,V,W.
// RULE12: Sensor event count rises clockwise, wrapping from 0xffff to zero.
// RULE13: Sensor event count falls counter-clockwise, wrapping zero to 0xffff.
// RULE14: Sensor event count compare match raises an interrupt.
// RULE15: Sensor timer counts clock cycles, clears on edge pulse, wraps 24 bit.
// RULE16: Sensor timer copies the count to capture on each edge pulse.
// RULE17: Soft capture bit copies the count to capture at any time.
// RULE18: Sensor timer compare match interrupts as interval time error.
// RULE19: Writing run enable zero clears the direction flag.
// RULE20: Sensor timer sets reverse error on direction change; read clears.
// RULE21: Capture register keeps its value; only reset clears it.
// RULE22: Timer mode: 24-bit up count, clear by software, compare or Z.
// RULE23: Timer Z trigger clears on Z rise, or on Z fall when select set.
// RULE24: All sensor pins pass a two-flop synchroniser before decoding.
package ehpc_pkg;
  localparam int CNT_W = 24;
  localparam int HALF_W = 16;
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] RELOAD_OFS = 5'h04;
  localparam logic [4:0] CMP_OFS = 5'h08;
  localparam logic [4:0] CAP_OFS = 5'h0c;
  localparam logic [4:0] CNT_OFS = 5'h10;
  localparam logic [4:0] DIV_OFS = 5'h14;
  localparam int B_RUN = 0;
  localparam int B_MODE = 1;
  localparam int B_ZEN = 3;
  localparam int B_P3 = 4;
  localparam int B_COMPARE_ENABLE = 5;
  localparam int B_ZESEL = 6;
  localparam int B_CLR = 7;
  localparam int B_SCAP = 8;
  localparam int B_TCLR = 9;
  localparam int B_POE = 10;
  localparam int B_DIR = 16;
  localparam int B_ZSEEN = 17;
  localparam int B_REV = 18;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [23:0] CMP_RST = 24'h000000;
  localparam logic [15:0] MAX16 = 16'hffff;
  localparam logic [2:0] HALL_BAD = 3'h7;
  localparam logic [2:0] HALL_LAST = 3'h5;
  typedef enum logic [1:0] {
    MODE_ENC = 2'b00,
    MODE_EVT = 2'b01,
    MODE_TCNT = 2'b10,
    MODE_TMR = 2'b11
  } ehpc_mode_e;
endpackage : ehpc_pkg

/* File: logic/ehpc_top.sv */
// Encoder and Hall sensor position counter with Avalon-MM registers.
// Assumes sensor pins are asynchronous; bus and core share CLK.
`timescale 1ns/1ps
module ehpc_top #(
  parameter int DIV_W = 16
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic ENC_Z,
  input wire logic HALL_U,
  input wire logic HALL_V,
  input wire logic HALL_W,
  output logic EDGE_PULSE,
  output logic DIRECTION,
  output logic CMP_IRQ,
  output logic PULSE_OUT,
  output logic PULSE_OE
);
  import ehpc_pkg::*;

  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_p;
  logic run;
  ehpc_mode_e mode;
  logic zen;
  logic p3;
  logic compare_enable;
  logic zesel;
  logic tclr;
  logic poe;
  logic dir;
  logic zseen;
  logic rev;
  logic [15:0] reload;
  logic [23:0] cmp;
  logic [23:0] cap;
  logic [23:0] cnt;
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] divc;
  logic [23:0] next_cnt;
  logic [31:0] ctrl_rd;
  logic [31:0] rd_mux;

  // Hall state to phase index; the two illegal codes give no pulse
  function automatic logic [2:0] hall_idx(input logic [2:0] uvw);
    case (uvw)
      3'b100: hall_idx = 3'h0;
      3'b110: hall_idx = 3'h1;
      3'b010: hall_idx = 3'h2;
      3'b011: hall_idx = 3'h3;
      3'b001: hall_idx = 3'h4;
      3'b101: hall_idx = 3'h5;
      default: hall_idx = HALL_BAD;
    endcase
  endfunction : hall_idx

  // Pin order {W,V,U,Z,B,A}; the first stage feeds only the second
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_p <= '0;
    end else if (CE) begin
      pin_s1 <= {HALL_W, HALL_V, HALL_U, ENC_Z, ENC_B, ENC_A}; // [RULE24]
      pin_s2 <= pin_s1; // [RULE24]
      pin_p <= pin_s2;
    end
  end

  wire a_c = pin_s2[0];
  wire b_c = pin_s2[1];
  wire z_c = pin_s2[2];
  wire u_c = pin_s2[3];
  wire v_c = pin_s2[4];
  wire a_p = pin_p[0];
  wire b_p = pin_p[1];
  wire z_p = pin_p[2];
  wire u_p = pin_p[3];
  wire v_p = pin_p[4];
  wire z_rise = z_c & ~z_p;
  wire z_fall = ~z_c & z_p;

  // Two-channel quadrature: a single-bit change is one pulse
  wire ab_step = (a_c ^ a_p) ^ (b_c ^ b_p); // [RULE1]
  wire ab_cw = a_c ^ b_p;
  wire uv_step = (u_c ^ u_p) ^ (v_c ^ v_p); // [RULE11]
  wire uv_cw = u_c ^ v_p;
  // The decode wants U as its top bit, the reverse of the pin order
  wire [2:0] h_ic = hall_idx({u_c, v_c, pin_s2[5]});
  wire [2:0] h_ip = hall_idx({u_p, v_p, pin_p[5]});
  wire [2:0] h_inc = (h_ip == HALL_LAST) ? 3'h0 : h_ip + 3'h1;
  // Six steps per cycle; a jump across two states counts as nothing
  wire h3_ok = (h_ic != HALL_BAD) & (h_ip != HALL_BAD);
  wire h3_step = h3_ok & (h_ic != h_ip); // [RULE11]
  wire h3_cw = h_ic == h_inc;
  wire h3_dirok = h3_cw | (h_ip == ((h_ic == HALL_LAST) ? 3'h0
                  : h_ic + 3'h1));

  wire is_enc = mode == MODE_ENC;
  wire is_evt = mode == MODE_EVT;
  wire is_tcnt = mode == MODE_TCNT;
  wire is_tmr = mode == MODE_TMR;
  wire hall_pulse = p3 ? (h3_step & h3_dirok) : uv_step; // [RULE11]
  wire pulse = run & (is_enc ? ab_step : (is_tmr ? 1'b0 : hall_pulse));
  wire pcw = is_enc ? ab_cw : (p3 ? h3_cw : uv_cw);
  wire cur_cw = pulse ? pcw : dir;
  wire enc_z = run & is_enc & zen & (cur_cw ? z_rise : z_fall); // [RULE4]
  wire tmr_z = run & is_tmr & zen & (zesel ? z_fall : z_rise); // [RULE23]

  // Bus: one wait state, read data latched on the first request cycle
  wire req = AVS_READ | AVS_WRITE;
  wire take = req & AVS_WAITREQUEST;
  wire wr = AVS_WRITE & ~AVS_WAITREQUEST;
  wire wr_ctrl = wr & (AVS_ADDRESS == CTRL_OFS);
  wire wr_rel = wr & (AVS_ADDRESS == RELOAD_OFS);
  wire wr_cmp = wr & (AVS_ADDRESS == CMP_OFS);
  wire wr_div = wr & (AVS_ADDRESS == DIV_OFS);
  // Clearing on the latch edge keeps a flag set at that edge
  wire rd_ctrl = take & AVS_READ & (AVS_ADDRESS == CTRL_OFS);
  wire clr = wr_ctrl & AVS_WRITEDATA[B_CLR];
  wire scap = wr_ctrl & AVS_WRITEDATA[B_SCAP];
  wire stop = wr_ctrl & ~AVS_WRITEDATA[B_RUN];

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[B_RUN] = run;
    ctrl_rd[B_MODE+1:B_MODE] = mode;
    ctrl_rd[B_ZEN] = zen;
    ctrl_rd[B_P3] = p3;
    ctrl_rd[B_COMPARE_ENABLE] = compare_enable;
    ctrl_rd[B_ZESEL] = zesel;
    ctrl_rd[B_TCLR] = tclr;
    ctrl_rd[B_POE] = poe;
    ctrl_rd[B_DIR] = dir;
    ctrl_rd[B_ZSEEN] = zseen;
    ctrl_rd[B_REV] = rev;
  end

  // Upper count bits stay zero in the 16-bit modes once cleared or stepped; a count left by a 24-bit mode keeps them until then
  always_comb begin
    case (AVS_ADDRESS)
      CTRL_OFS: rd_mux = ctrl_rd;
      RELOAD_OFS: rd_mux = {16'h0000, reload};
      CMP_OFS: rd_mux = {8'h00, cmp};
      CAP_OFS: rd_mux = {8'h00, cap};
      CNT_OFS: rd_mux = {8'h00, cnt};
      DIV_OFS: rd_mux = 32'(div);
      default: rd_mux = '0;
    endcase
  end

  wire [15:0] lo = cnt[15:0];
  wire [15:0] lo_up = lo + 16'h0001;
  wire [15:0] lo_dn = lo - 16'h0001;
  wire [23:0] up24 = cnt + 24'h000001;

  always_comb begin
    next_cnt = cnt;
    if (clr) begin
      next_cnt = '0; // [RULE6]
    end else if (run) begin
      case (mode)
        MODE_ENC: begin
          if (enc_z) begin
            next_cnt = '0; // [RULE4] [RULE5]
          end else if (pulse & pcw) begin
            next_cnt = (lo == reload) ? '0 : {8'h00, lo_up}; // [RULE2]
          end else if (pulse) begin
            next_cnt = (lo == '0) ? {8'h00, reload}
                       : {8'h00, lo_dn}; // [RULE3]
          end
        end
        MODE_EVT: begin
          if (pulse) begin
            next_cnt = {8'h00, pcw ? lo_up : lo_dn}; // [RULE12] [RULE13]
          end
        end
        MODE_TCNT: begin
          next_cnt = pulse ? '0 : up24; // [RULE15]
        end
        MODE_TMR: begin
          if (tmr_z | (tclr & (cnt == cmp))) begin
            next_cnt = '0; // [RULE22]
          end else begin
            next_cnt = up24; // [RULE22]
          end
        end
        default: next_cnt = cnt;
      endcase
    end
  end

  wire wide = is_tcnt | is_tmr;
  wire hit = wide ? (next_cnt == cmp) : (next_cnt[15:0] == cmp[15:0]);
  wire mute = is_enc & zen & ~zseen; // [RULE9]
  // A match fires once, when the count moves onto the compare value
  wire match = compare_enable & run & ~clr & (next_cnt != cnt) & hit & ~mute;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= '0;
    end else if (CE) begin
      AVS_WAITREQUEST <= ~take;
      if (take & AVS_READ) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mode <= MODE_ENC;
      {zen, p3, compare_enable, zesel, tclr, poe} <= '0;
      reload <= RELOAD_RST;
      cmp <= CMP_RST;
      div <= '0;
    end else if (CE) begin
      if (wr_ctrl) begin
        mode <= ehpc_mode_e'(AVS_WRITEDATA[B_MODE+1:B_MODE]);
        zen <= AVS_WRITEDATA[B_ZEN];
        p3 <= AVS_WRITEDATA[B_P3];
        compare_enable <= AVS_WRITEDATA[B_COMPARE_ENABLE];
        zesel <= AVS_WRITEDATA[B_ZESEL];
        tclr <= AVS_WRITEDATA[B_TCLR];
        poe <= AVS_WRITEDATA[B_POE];
      end
      if (wr_rel) begin
        reload <= AVS_WRITEDATA[15:0];
      end
      if (wr_cmp) begin
        cmp <= AVS_WRITEDATA[23:0];
      end
      if (wr_div) begin
        div <= AVS_WRITEDATA[DIV_W-1:0];
      end
    end
  end

  // Software write wins over the automatic stop in the same cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      run <= 1'b0;
    end else if (CE) begin
      if (wr_ctrl) begin
        run <= AVS_WRITEDATA[B_RUN];
      end else if (is_enc & pulse & ~pcw & ~zseen) begin
        run <= 1'b0; // [RULE10]
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      dir <= 1'b0;
      zseen <= 1'b0;
      rev <= 1'b0;
    end else if (CE) begin
      if (stop) begin
        dir <= 1'b0; // [RULE19]
      end else if (pulse) begin
        dir <= pcw; // [RULE7]
      end
      if (enc_z) begin
        zseen <= 1'b1;
      end else if (stop) begin
        zseen <= 1'b0;
      end
      if (is_tcnt & pulse & (pcw != dir)) begin
        rev <= 1'b1; // [RULE20]
      end else if (rd_ctrl) begin
        rev <= 1'b0; // [RULE20]
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cnt <= '0;
      cap <= '0; // [RULE21]
    end else if (CE) begin
      cnt <= next_cnt;
      if (scap) begin
        cap <= cnt; // [RULE17]
      end else if ((is_tcnt & pulse) | tmr_z) begin
        cap <= cnt; // [RULE16] [RULE22]
      end
    end
  end

  // Output toggles every div+1 pulses, a period of 2*(div+1) pulses
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      divc <= '0;
      PULSE_OUT <= 1'b0;
      PULSE_OE <= 1'b0;
      EDGE_PULSE <= 1'b0;
      DIRECTION <= 1'b0;
      CMP_IRQ <= 1'b0;
    end else if (CE) begin
      PULSE_OE <= poe; // [RULE8]
      EDGE_PULSE <= pulse; // [RULE1]
      DIRECTION <= dir;
      CMP_IRQ <= match; // [RULE9] [RULE14] [RULE18]
      if (pulse & (divc == div)) begin
        divc <= '0;
        PULSE_OUT <= ~PULSE_OUT; // [RULE8]
      end else if (pulse) begin
        divc <= divc + 1'b1;
      end
    end
  end

  default clocking dc @(posedge CLK); endclocking
  default disable iff (RESET);

  a_clr_zero: assert property (CE & clr |=> cnt == '0) // [RULE6]
    else $error("counter not cleared by write");
  a_enc_wrap: assert property (CE & is_enc & pulse & pcw & ~enc_z // [RULE2]
    & ~clr & (lo == reload) |=> cnt == '0)
    else $error("encoder up count did not wrap at reload");
  a_enc_reload: assert property (CE & is_enc & pulse & ~pcw & ~enc_z // [RULE3]
    & ~clr & (cnt == '0) |=> cnt[15:0] == $past(reload))
    else $error("encoder down count did not reload");
  a_enc_zclr: assert property (CE & enc_z & ~clr // [RULE5]
    |=> cnt == '0)
    else $error("Z edge did not clear the count");
  a_evt_wrap: assert property (CE & is_evt & pulse & ~pcw & ~clr // [RULE13]
    & (cnt == '0) |=> cnt[15:0] == MAX16)
    else $error("event count did not wrap to top");
  a_tcnt_cap: assert property (CE & is_tcnt & pulse & ~scap // [RULE16]
    |=> cap == $past(cnt) && cnt == '0)
    else $error("timer capture or clear missed");
  a_dir_stop: assert property (CE & stop |=> ~dir ##1 ~DIRECTION) // [RULE19]
    else $error("direction kept after stop");
  a_rev_set: assert property (CE & is_tcnt & pulse & (pcw != dir) // [RULE20]
    |=> rev)
    else $error("reverse error not flagged");
  a_cap_hold: assert property (CE & ~scap & ~pulse & ~tmr_z // [RULE21]
    |=> $stable(cap))
    else $error("capture changed without cause");
endmodule : ehpc_top

/* File: bench/ehpc_sensor_model.sv */
// Stand-in for the sensors: quadrature encoder with index, Hall rotor set.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/1ps
module ehpc_sensor_model (
  input wire logic clk,
  output logic enc_a,
  output logic enc_b,
  output logic enc_z,
  output logic hall_u,
  output logic hall_v,
  output logic hall_w
);
  logic [1:0] ab_seq [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [2:0] uvw_seq [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  int ab_i = 0;
  int uvw_i = 0;
  initial begin
    {enc_a, enc_b, enc_z} = 3'h0;
    {hall_u, hall_v, hall_w} = 3'h4;
  end
  // Each level is held gap edges; faster changes would be lost in sync
  task automatic enc_move(input int d, input logic z, input int gap);
    ab_i = (ab_i + d + 4) % 4;
    {enc_a, enc_b} <= ab_seq[ab_i];
    enc_z <= z;
    repeat (gap) @(posedge clk);
  endtask : enc_move
  task automatic hall_move(input int d, input int gap);
    uvw_i = (uvw_i + d + 6) % 6;
    {hall_u, hall_v, hall_w} <= uvw_seq[uvw_i];
    repeat (gap) @(posedge clk);
  endtask : hall_move
endmodule : ehpc_sensor_model

/* File: bench/test_encoder_hall_position_counter.sv */
// Self-checking bench: register accesses and sensor steps with expectations.
// Assumes ehpc_pkg and ehpc_top are compiled first.
`timescale 1ns/1ps
module test_encoder_hall_position_counter;
  import ehpc_pkg::*;
  logic clk, reset, rd_en, wr_en, wait_req, edge_pulse, direction;
  logic cmp_irq, pulse_out, pulse_oe, enc_a, enc_b, enc_z;
  logic hall_u, hall_v, hall_w;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, rd;
  int fail_count = 0;
  int num_checks = 0;
  int n_edge = 0;
  int n_irq = 0;
  int e0, i0;
  ehpc_top uut (.CLK(clk), .RESET(reset), .CE(1'b1), .AVS_ADDRESS(addr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .ENC_A(enc_a),
    .ENC_B(enc_b), .ENC_Z(enc_z), .HALL_U(hall_u), .HALL_V(hall_v),
    .HALL_W(hall_w), .EDGE_PULSE(edge_pulse), .DIRECTION(direction),
    .CMP_IRQ(cmp_irq), .PULSE_OUT(pulse_out), .PULSE_OE(pulse_oe));
  ehpc_sensor_model sens (.clk(clk), .enc_a(enc_a), .enc_b(enc_b),
    .enc_z(enc_z), .hall_u(hall_u), .hall_v(hall_v), .hall_w(hall_w));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (edge_pulse === 1'b1)
      n_edge <= n_edge + 1;
    if (cmp_irq === 1'b1)
      n_irq <= n_irq + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // A request is raised one edge after the last one ended, never at it
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    wr_en <= 1'b0;
  endtask : bus_write
  task automatic bus_read(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    rd = rdata;
    rd_en <= 1'b0;
  endtask : bus_read
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus_read(a);
    chk($sformatf("reg %h", a), rd, e);
  endtask : rchk
  task automatic snap;
    e0 = n_edge;
    i0 = n_irq;
  endtask : snap
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    addr = 5'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 32'h0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rchk(CTRL_OFS, 32'h0);
    rchk(RELOAD_OFS, 32'h0);
    rchk(CMP_OFS, 32'h0);
    rchk(CAP_OFS, 32'h0);
    rchk(CNT_OFS, 32'h0);
    rchk(5'h18, 32'h0);
    // Encoder: reload 3, run, pulse output driven
    bus_write(RELOAD_OFS, 32'h3);
    bus_write(DIV_OFS, 32'h1);
    bus_write(CTRL_OFS, 32'h481);
    snap();
    repeat (5) sens.enc_move(1, 1'b0, 6);
    chk("edges", n_edge - e0, 32'h5);
    rchk(CNT_OFS, 32'h1);
    rchk(CTRL_OFS, 32'h00010401);
    chk("pulse_oe", {31'h0, pulse_oe}, 32'h1);
    chk("direction", {31'h0, direction}, 32'h1);
    bus_write(CTRL_OFS, 32'h481);
    rchk(CNT_OFS, 32'h0);
    sens.enc_move(-1, 1'b0, 6);
    rchk(CNT_OFS, 32'h3);
    rchk(CTRL_OFS, 32'h00000400);
    chk("direction", {31'h0, direction}, 32'h0);
    chk("pulse_out", {31'h0, pulse_out}, 32'h1);
    // Index clear with compare muted until the index is seen
    bus_write(CMP_OFS, 32'h2);
    bus_write(CTRL_OFS, 32'ha9);
    snap();
    repeat (2) sens.enc_move(1, 1'b0, 6);
    chk("irq", n_irq - i0, 32'h0);
    sens.enc_move(0, 1'b1, 6);
    rchk(CNT_OFS, 32'h0);
    rchk(CTRL_OFS, 32'h00030029);
    repeat (2) sens.enc_move(1, 1'b1, 6);
    chk("irq", n_irq - i0, 32'h1);
    sens.enc_move(0, 1'b0, 6);
    sens.enc_move(1, 1'b1, 6);
    rchk(CNT_OFS, 32'h0);
    // Hall event count, three-phase then two-phase
    bus_write(CMP_OFS, 32'h3);
    bus_write(CTRL_OFS, 32'hb3);
    sens.hall_move(-1, 6);
    rchk(CNT_OFS, 32'hffff);
    sens.hall_move(1, 6);
    rchk(CNT_OFS, 32'h0);
    snap();
    repeat (6) sens.hall_move(1, 6);
    chk("edges", n_edge - e0, 32'h6);
    chk("irq", n_irq - i0, 32'h1);
    bus_write(CTRL_OFS, 32'ha3);
    snap();
    repeat (6) sens.hall_move(1, 6);
    chk("edges", n_edge - e0, 32'h4);
    // Hall interval timing: steps exactly 20 cycles apart, compare 18
    bus_write(CMP_OFS, 32'h12);
    bus_write(CTRL_OFS, 32'h94);
    bus_write(CTRL_OFS, 32'hb5);
    sens.hall_move(-1, 6);
    rchk(CTRL_OFS, 32'h00000035);
    snap();
    repeat (3) sens.hall_move(1, 20);
    chk("irq", n_irq - i0, 32'h2);
    rchk(CAP_OFS, 32'h13);
    rchk(CTRL_OFS, 32'h00050035);
    rchk(CTRL_OFS, 32'h00010035);
    bus_write(CTRL_OFS, 32'h94);
    rchk(CTRL_OFS, 32'h00000014);
    rchk(CAP_OFS, 32'h13);
    // Timer: compare 5 with compare clear gives a match every 6 cycles
    bus_write(CMP_OFS, 32'h5);
    bus_write(CTRL_OFS, 32'h2a7);
    repeat (10) @(posedge clk);
    snap();
    repeat (60) @(posedge clk);
    chk("irq", n_irq - i0, 32'ha);
    sens.enc_move(0, 1'b1, 6);
    bus_write(CTRL_OFS, 32'hcf);
    repeat (100) @(posedge clk);
    sens.enc_move(0, 1'b0, 6);
    bus_read(CNT_OFS);
    chk("cnt_small", {31'h0, rd < 32'h28}, 32'h1);
    // Stop at zero, then soft capture overwrites the Z-trigger capture
    bus_write(CTRL_OFS, 32'h86);
    bus_write(CTRL_OFS, 32'h106);
    rchk(CAP_OFS, 32'h0);
    final_report();
  end
endmodule : test_encoder_hall_position_counter
